// [logic/velocity_pkg.sv]
// constants, field layout and encodings of the velocity profile command block
package velocity_pkg;

  // =====================================================================
  // clock and sizes
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int NUM_AXES_DEF = 4;
  localparam int VEL_W = 22;
  localparam int DUR_W = 18;
  localparam int URATE_W = 14;
  localparam int ADDR_W = 8;

  // =====================================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RAMP = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_ARG0 = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_ARG_MASK = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CMD = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_REPORT = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_QCOST = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_URATE = 8'h2C;

  // =====================================================================
  // field positions
  localparam int MODE_LSB = 0;
  localparam int AXIS_LSB = 4;
  localparam int AXIS_W = 2;
  localparam int RAMP_LSB = 0;
  localparam int OP_LSB = 0;
  localparam int ST_ERR = 0;
  localparam int ST_WAIT = 1;
  localparam int ST_STREAM = 2;
  localparam int ST_PEND = 3;
  localparam int QC_ARG_LSB = 8;

  // =====================================================================
  // values
  localparam logic [VEL_W-1:0] BASE_DEF = 22'h000000;
  localparam logic [VEL_W-1:0] PEAK_DEF = 22'(200_000);
  localparam logic [31:0] VEL_MAX = 32'(4_000_000);
  localparam logic [31:0] DUR_MAX = 32'(200_000);
  localparam logic [URATE_W-1:0] URATE_DEF = 14'(1024);
  localparam logic [31:0] URATE_A = 32'(1024);
  localparam logic [31:0] URATE_B = 32'(2048);
  localparam logic [31:0] URATE_C = 32'(4096);
  localparam logic [31:0] URATE_D = 32'(8192);

  // queue entries per axis: command, argument
  localparam logic [7:0] QC_ONE = 8'h01;
  localparam logic [7:0] QC_TWO = 8'h02;
  localparam logic [7:0] QC_THREE = 8'h03;
  localparam logic [7:0] QC_PARA_ARG = 8'(26);
  localparam logic [7:0] QC_NONE = 8'h00;

  // =====================================================================
  // encodings
  typedef enum logic [1:0] {
    MODE_SINGLE, MODE_ALL, MODE_MULTI, MODE_CONTOUR
  } mode_t;

  typedef enum logic [2:0] {
    RAMP_LINEAR, RAMP_SHORT_PARA, RAMP_OTHER_PARA, RAMP_COSINE, RAMP_CUSTOM, RAMP_SCURVE
  } ramp_t;

  typedef enum logic [3:0] {
    OP_NONE, OP_BASE_SET, OP_BASE_REPORT, OP_PEAK_SET, OP_PEAK_REPORT,
    OP_STREAM, OP_WAIT_ALL, OP_RATE_SET
  } op_t;

endpackage

// [logic/rate_pulse_gen.sv]
// phase accumulator that turns a rate in events per second into one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
module rate_pulse_gen #(
  parameter int unsigned CLK_HZ = velocity_pkg::CLK_HZ,
  parameter int RATE_W = velocity_pkg::VEL_W
) (
  input wire logic i_sys_clk,              // system clock
  input wire logic i_rst_b,                // sync reset, low active
  input wire logic i_clear,                // restart the phase
  input wire logic [RATE_W-1:0] i_rate,    // events per second
  output logic o_pulse                     // one cycle per event
);
  import velocity_pkg::*;

  localparam int ACC_W = $clog2(CLK_HZ) + 2;
  localparam logic [ACC_W-1:0] LIMIT = ACC_W'(CLK_HZ);

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic pulse;
  } gen_state_t;

  gen_state_t s_r;
  gen_state_t s_nxt;
  logic [ACC_W-1:0] sum;

  // =====================================================================
  // accumulate
  // rate never exceeds the clock, so at most one event per cycle
  always_comb begin
    sum = s_r.acc + ACC_W'(i_rate);
    s_nxt = s_r;
    if (!i_rst_b || i_clear) begin
      s_nxt = '0;
    end else if (sum >= LIMIT) begin
      s_nxt.acc = sum - LIMIT;
      s_nxt.pulse = 1'b1;
    end else begin
      s_nxt.acc = sum;
      s_nxt.pulse = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    s_r <= s_nxt;
  end

  assign o_pulse = s_r.pulse;

endmodule
`default_nettype wire

// [logic/velocity_profile_commands.sv]
// per-axis base/peak velocity, velocity streaming and all-axes wait barrier
//
// Function
// - linear moves jump to base rate, ramp, and mirror that on deceleration
// - base rate only applies to linear ramps; other ramps ignore it silently
// - base rate defaults to zero; base set above the peak rate is rejected
// - peak set below base makes moves start at peak minus one
// - base report returns current axis value, single-axis modes only
// - peak set loads axes; default 200000, accepted range 1 to 4000000
// - all-axes peak set leaves unmasked operand axes unchanged
// - peak set costs 1/1 linear, 2/26 short parabolic, else rejected
// - peak report returns current axis value, single-axis modes only
// - streaming drives constant step trains on first two axes, no ramps
// - stream operands: duration 1..200000 intervals, two signed rates to 4000000
// - streaming starts as soon as the command is complete
// - all-axes wait holds later commands until every axis is idle
// - all-axes wait costs two command and zero argument entries per axis
// - update rate is 1024, 2048, 4096 or 8192; anything else errors
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module velocity_profile_commands #(
  parameter int NUM_AXES = velocity_pkg::NUM_AXES_DEF
) (
  input wire logic i_sys_clk,                                        // 10 MHz clock
  input wire logic i_rst_b,                                          // sync reset, low active
  input wire logic i_psel,                                           // apb select
  input wire logic i_penable,                                        // apb enable
  input wire logic i_pwrite,                                         // apb write
  input wire logic [velocity_pkg::ADDR_W-1:0] i_paddr,               // apb byte address
  input wire logic [31:0] i_pwdata,                                  // apb write data
  input wire logic [NUM_AXES-1:0] i_axis_busy,                       // axis moving
  output logic [31:0] o_prdata,                                      // apb read data
  output logic o_pready,                                             // apb ready
  output logic o_pslverr,                                            // apb error
  output logic [NUM_AXES-1:0][velocity_pkg::VEL_W-1:0] o_start_vel,  // ramp start/end rate
  output logic [NUM_AXES-1:0][velocity_pkg::VEL_W-1:0] o_peak_vel,   // peak rate
  output logic o_hold,                                               // wait barrier active
  output logic o_stream_active,                                      // streaming running
  output logic o_step_x,                                             // first axis step
  output logic o_dir_x,                                              // first axis dir, 1 neg
  output logic o_step_y,                                             // second axis step
  output logic o_dir_y                                               // second axis dir, 1 neg
);
  import velocity_pkg::*;

  localparam logic [ADDR_W-1:0] OFS_ARG_LAST = ADDR_W'(OFS_ARG0 + 4 * (NUM_AXES - 1));
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    mode_t mode;
    logic [AXIS_W-1:0] axis;
    ramp_t [NUM_AXES-1:0] ramp;
    logic [NUM_AXES-1:0][31:0] arg;
    logic [NUM_AXES-1:0] mask;
    logic [NUM_AXES-1:0][VEL_W-1:0] base;
    logic [NUM_AXES-1:0][VEL_W-1:0] peak;
    logic [NUM_AXES-1:0][VEL_W-1:0] start;
    logic [31:0] report;
    logic [7:0] qc_cmd;
    logic [7:0] qc_arg;
    logic err;
    logic wait_all;
    logic [URATE_W-1:0] urate;
    logic s_act;
    logic [DUR_W-1:0] s_left;
    logic [VEL_W-1:0] s_xr;
    logic [VEL_W-1:0] s_yr;
    logic s_xd;
    logic s_yd;
    logic p_val;
    logic [DUR_W-1:0] p_dur;
    logic [VEL_W-1:0] p_xr;
    logic [VEL_W-1:0] p_yr;
    logic p_xd;
    logic p_yd;
    logic tick_clr;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  logic tick;
  logic step_x;
  logic step_y;
  // =====================================================================
  // helpers
  function automatic logic [VEL_W-1:0] start_rate(ramp_t r, logic [VEL_W-1:0] b,
                                                  logic [VEL_W-1:0] p);
    if (r != RAMP_LINEAR) begin
      start_rate = BASE_DEF;
    end else if (b > p) begin
      start_rate = p - VEL_W'(1);
    end else begin
      start_rate = b;
    end
  endfunction
  function automatic logic [31:0] magnitude(logic [31:0] v);
    magnitude = v[31] ? (~v + 32'h00000001) : v;
  endfunction
  function automatic logic rate_ok(logic [31:0] v);
    rate_ok = magnitude(v) <= VEL_MAX;
  endfunction

  // =====================================================================
  // state update
  always_comb begin
    logic access;
    logic done;
    logic wr;
    logic single;
    logic group;
    logic sel;
    logic stall;
    logic [31:0] val;
    op_t op;
    access = i_psel && i_penable;
    done = access && s_r.pready;
    wr = done && i_pwrite && !s_r.pslverr;
    single = (s_r.mode == MODE_SINGLE);
    group = (s_r.mode == MODE_ALL) || (s_r.mode == MODE_MULTI);
    sel = 1'b0;
    val = '0;
    op = op_t'(i_pwdata[OP_LSB +: 4]);
    // later commands wait behind the barrier by holding the bus
    stall = s_r.wait_all && i_pwrite && (i_paddr == OFS_CMD);
    s_nxt = s_r;
    s_nxt.tick_clr = 1'b0;
    // ---- bus answer: one wait cycle, then ready
    if (done) begin
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;
    end else if (access && !stall) begin
      s_nxt.pready = 1'b1;
      s_nxt.pslverr = 1'b0;
      s_nxt.prdata = '0;
      if (i_paddr == OFS_MODE) begin
        s_nxt.prdata[MODE_LSB +: 2] = s_r.mode;
        s_nxt.prdata[AXIS_LSB +: AXIS_W] = s_r.axis;
      end else if (i_paddr == OFS_RAMP) begin
        s_nxt.prdata[RAMP_LSB +: 3] = s_r.ramp[s_r.axis];
      end else if (i_paddr >= OFS_ARG0 && i_paddr <= OFS_ARG_LAST && i_paddr[1:0] == 2'b00) begin
        s_nxt.prdata = s_r.arg[(i_paddr - OFS_ARG0) >> 2];
      end else if (i_paddr == OFS_ARG_MASK) begin
        s_nxt.prdata[NUM_AXES-1:0] = s_r.mask;
      end else if (i_paddr == OFS_CMD) begin
        s_nxt.prdata = '0;
      end else if (i_paddr == OFS_STATUS) begin
        s_nxt.prdata[ST_ERR] = s_r.err;
        s_nxt.prdata[ST_WAIT] = s_r.wait_all;
        s_nxt.prdata[ST_STREAM] = s_r.s_act;
        s_nxt.prdata[ST_PEND] = s_r.p_val;
      end else if (i_paddr == OFS_REPORT) begin
        s_nxt.prdata = s_r.report;
      end else if (i_paddr == OFS_QCOST) begin
        s_nxt.prdata[7:0] = s_r.qc_cmd;
        s_nxt.prdata[QC_ARG_LSB +: 8] = s_r.qc_arg;
      end else if (i_paddr == OFS_URATE) begin
        s_nxt.prdata[URATE_W-1:0] = s_r.urate;
      end else begin
        s_nxt.pslverr = 1'b1;
      end
    end
    // ---- barrier releases once every axis and the stream are idle
    if (s_r.wait_all && i_axis_busy == '0 && !s_r.s_act && !s_r.p_val) begin
      s_nxt.wait_all = 1'b0;
    end
    // ---- streaming segments advance on update interval ticks
    if (tick && s_r.s_act) begin
      if (s_r.s_left > DUR_W'(1)) begin
        s_nxt.s_left = s_r.s_left - DUR_W'(1);
      end else if (s_r.p_val) begin
        s_nxt.s_left = s_r.p_dur;
        s_nxt.s_xr = s_r.p_xr;
        s_nxt.s_yr = s_r.p_yr;
        s_nxt.s_xd = s_r.p_xd;
        s_nxt.s_yd = s_r.p_yd;
        s_nxt.p_val = 1'b0;
      end else begin
        s_nxt.s_act = 1'b0;
        s_nxt.s_xr = '0;
        s_nxt.s_yr = '0;
      end
    end
    // ---- register writes
    if (wr) begin
      if (i_paddr == OFS_MODE) begin
        s_nxt.mode = mode_t'(i_pwdata[MODE_LSB +: 2]);
        s_nxt.axis = i_pwdata[AXIS_LSB +: AXIS_W];
      end else if (i_paddr == OFS_RAMP) begin
        s_nxt.ramp[s_r.axis] = ramp_t'(i_pwdata[RAMP_LSB +: 3]);
      end else if (i_paddr >= OFS_ARG0 && i_paddr <= OFS_ARG_LAST) begin
        s_nxt.arg[(i_paddr - OFS_ARG0) >> 2] = i_pwdata;
      end else if (i_paddr == OFS_ARG_MASK) begin
        s_nxt.mask = i_pwdata[NUM_AXES-1:0];
      end else if (i_paddr == OFS_STATUS) begin
        s_nxt.err = s_r.err && !i_pwdata[ST_ERR];
      end else if (i_paddr == OFS_CMD) begin
        s_nxt.qc_cmd = QC_NONE;
        s_nxt.qc_arg = QC_NONE;
        unique case (op)
          OP_BASE_SET: begin
            if (!single && !group) begin
              s_nxt.err = 1'b1;
            end else begin
              s_nxt.qc_cmd = QC_ONE;
              s_nxt.qc_arg = QC_ONE;
              for (int i = 0; i < NUM_AXES; i++) begin
                sel = single ? (AXIS_W'(i) == s_r.axis) : s_r.mask[i];
                val = single ? s_r.arg[0] : s_r.arg[i];
                if (sel && val > 32'(s_r.peak[i])) begin
                  s_nxt.err = 1'b1;
                end else if (sel) begin
                  s_nxt.base[i] = val[VEL_W-1:0];
                end
              end
            end
          end
          OP_PEAK_SET: begin
            if (!single && !group) begin
              s_nxt.err = 1'b1;
            end else begin
              for (int i = 0; i < NUM_AXES; i++) begin
                sel = single ? (AXIS_W'(i) == s_r.axis) : s_r.mask[i];
                val = single ? s_r.arg[0] : s_r.arg[i];
                if (sel && s_r.ramp[i] != RAMP_LINEAR && s_r.ramp[i] != RAMP_SHORT_PARA) begin
                  s_nxt.err = 1'b1;
                end else if (sel && (val == '0 || val > VEL_MAX)) begin
                  s_nxt.err = 1'b1;
                end else if (sel) begin
                  s_nxt.peak[i] = val[VEL_W-1:0];
                  s_nxt.qc_cmd = (s_r.ramp[i] == RAMP_LINEAR) ? QC_ONE : QC_TWO;
                  s_nxt.qc_arg = (s_r.ramp[i] == RAMP_LINEAR) ? QC_ONE : QC_PARA_ARG;
                end
              end
            end
          end
          OP_BASE_REPORT: begin
            if (single) begin
              s_nxt.report = 32'(s_r.base[s_r.axis]);
            end else begin
              s_nxt.err = 1'b1;
            end
          end
          OP_PEAK_REPORT: begin
            if (single) begin
              s_nxt.report = 32'(s_r.peak[s_r.axis]);
            end else begin
              s_nxt.err = 1'b1;
            end
          end
          OP_STREAM: begin
            if (!single || s_r.axis != '0) begin
              s_nxt.err = 1'b1;
            end else if (s_r.arg[0] == '0 || s_r.arg[0] > DUR_MAX
                         || !rate_ok(s_r.arg[1]) || !rate_ok(s_r.arg[2])) begin
              s_nxt.err = 1'b1;
            end else if (!s_r.s_act || (tick && s_r.s_left <= DUR_W'(1) && !s_r.p_val)) begin
              // idle, or the last segment ends on this tick: load now, restart the phase
              s_nxt.s_act = 1'b1;
              s_nxt.tick_clr = 1'b1;
              s_nxt.s_left = s_r.arg[0][DUR_W-1:0];
              s_nxt.s_xr = VEL_W'(magnitude(s_r.arg[1]));
              s_nxt.s_yr = VEL_W'(magnitude(s_r.arg[2]));
              s_nxt.s_xd = s_r.arg[1][31];
              s_nxt.s_yd = s_r.arg[2][31];
              s_nxt.qc_cmd = QC_TWO;
              s_nxt.qc_arg = QC_THREE;
            end else if (!s_r.p_val || (tick && s_r.s_left <= DUR_W'(1))) begin
              // one segment of look-ahead keeps segments seamless
              s_nxt.p_val = 1'b1;
              s_nxt.p_dur = s_r.arg[0][DUR_W-1:0];
              s_nxt.p_xr = VEL_W'(magnitude(s_r.arg[1]));
              s_nxt.p_yr = VEL_W'(magnitude(s_r.arg[2]));
              s_nxt.p_xd = s_r.arg[1][31];
              s_nxt.p_yd = s_r.arg[2][31];
              s_nxt.qc_cmd = QC_TWO;
              s_nxt.qc_arg = QC_THREE;
            end else begin
              s_nxt.err = 1'b1;
            end
          end
          OP_WAIT_ALL: begin
            if (group) begin
              s_nxt.wait_all = 1'b1;
              s_nxt.qc_cmd = QC_TWO;
              s_nxt.qc_arg = QC_NONE;
            end else begin
              s_nxt.err = 1'b1;
            end
          end
          OP_RATE_SET: begin
            if (single && (s_r.arg[0] == URATE_A || s_r.arg[0] == URATE_B
                           || s_r.arg[0] == URATE_C || s_r.arg[0] == URATE_D)) begin
              s_nxt.urate = s_r.arg[0][URATE_W-1:0];
            end else begin
              s_nxt.err = 1'b1;
            end
          end
          default: begin
            s_nxt.err = 1'b1;
          end
        endcase
      end
    end
    // ---- start rate follows base, peak and ramp; used for both ramp ends
    for (int i = 0; i < NUM_AXES; i++) begin
      s_nxt.start[i] = start_rate(s_nxt.ramp[i], s_nxt.base[i], s_nxt.peak[i]);
    end
    if (!i_rst_b) begin
      s_nxt = '0;
      s_nxt.mode = MODE_SINGLE;
      s_nxt.urate = URATE_DEF;
      for (int i = 0; i < NUM_AXES; i++) begin
        s_nxt.ramp[i] = RAMP_LINEAR;
        s_nxt.base[i] = BASE_DEF;
        s_nxt.peak[i] = PEAK_DEF;
        s_nxt.start[i] = BASE_DEF;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    s_r <= s_nxt;
  end

  // =====================================================================
  // interval tick and step trains
  rate_pulse_gen #(.CLK_HZ(CLK_HZ), .RATE_W(URATE_W)) u_tick (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_clear(s_r.tick_clr),
    .i_rate(s_r.urate),
    .o_pulse(tick)
  );
  rate_pulse_gen #(.CLK_HZ(CLK_HZ), .RATE_W(VEL_W)) u_step_x (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_clear(s_r.tick_clr),
    .i_rate(s_r.s_xr),
    .o_pulse(step_x)
  );
  rate_pulse_gen #(.CLK_HZ(CLK_HZ), .RATE_W(VEL_W)) u_step_y (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_clear(s_r.tick_clr),
    .i_rate(s_r.s_yr),
    .o_pulse(step_y)
  );

  assign o_prdata = s_r.prdata;
  assign o_pready = s_r.pready;
  assign o_pslverr = s_r.pslverr;
  assign o_start_vel = s_r.start;
  assign o_peak_vel = s_r.peak;
  assign o_hold = s_r.wait_all;
  assign o_stream_active = s_r.s_act;
  assign o_step_x = step_x;
  assign o_dir_x = s_r.s_xd;
  assign o_step_y = step_y;
  assign o_dir_y = s_r.s_yd;

endmodule
`default_nettype wire

// [verif/velocity_profile_commands_sva.sv]
// assertion checker for the velocity profile command block
`timescale 1ns/1ns
`default_nettype none
module velocity_profile_commands_sva
  import velocity_pkg::*;
#(parameter int NUM_AXES = 4) (
  input wire logic i_sys_clk,                         // clock
  input wire logic i_rst_b,                           // sync reset, low active
  input wire logic i_psel,                            // apb select
  input wire logic i_penable,                         // apb enable
  input wire logic i_pwrite,                          // apb write
  input wire logic [ADDR_W-1:0] i_paddr,              // apb address
  input wire logic [NUM_AXES-1:0] i_axis_busy,        // axis moving
  input wire logic o_pready,                          // apb ready
  input wire logic [NUM_AXES-1:0][VEL_W-1:0] o_start_vel, // start rate
  input wire logic [NUM_AXES-1:0][VEL_W-1:0] o_peak_vel,  // peak rate
  input wire logic o_hold,                            // barrier
  input wire logic o_stream_active,                   // streaming
  input wire logic o_step_x,                          // x step
  input wire logic o_step_y                           // y step
);
  // ====
  // properties
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  logic wr_done;
  assign wr_done = i_psel && i_penable && i_pwrite && o_pready;
  property p_ready_pulse; o_pready |=> !o_pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
  property p_reset_dflt;
    $rose(i_rst_b) |-> o_peak_vel[0] == PEAK_DEF && o_start_vel[0] == BASE_DEF;
  endproperty
  a_reset_dflt: assert property (p_reset_dflt) else $error("bad defaults");
  property p_start_le; $stable(o_peak_vel[0]) |-> o_start_vel[0] <= o_peak_vel[0]; endproperty
  a_start_le: assert property (p_start_le) else $error("start above peak");
  for (genvar g = 0; g < NUM_AXES; g++) begin : g_ax
    property p_peak_range; o_peak_vel[g] != '0 && 32'(o_peak_vel[g]) <= VEL_MAX; endproperty
    a_peak_range: assert property (p_peak_range) else $error("peak range");
  end
  property p_peak_wr; $changed(o_peak_vel) |-> $past(wr_done); endproperty
  a_peak_wr: assert property (p_peak_wr) else $error("peak moved alone");
  property p_step_on; o_step_x || o_step_y |-> o_stream_active || $past(o_stream_active);
  endproperty
  a_step_on: assert property (p_step_on) else $error("stray step");
  property p_hold_stall;
    i_psel && i_penable && i_pwrite && i_paddr == OFS_CMD && o_hold |=> !o_pready;
  endproperty
  a_hold_stall: assert property (p_hold_stall) else $error("cmd passed barrier");
  property p_hold_free; $fell(o_hold) |-> $past(i_axis_busy) == '0; endproperty
  a_hold_free: assert property (p_hold_free) else $error("early release");
  property p_hold_cause; $rose(o_hold) |-> $past(wr_done); endproperty
  a_hold_cause: assert property (p_hold_cause) else $error("hold w/o write");
  c_release: cover property ($fell(o_hold));
  c_stream: cover property ($rose(o_stream_active));
  c_step: cover property (o_step_y);
endmodule
bind velocity_profile_commands velocity_profile_commands_sva #(.NUM_AXES(NUM_AXES)) chk_u (
  .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_axis_busy(i_axis_busy), .o_pready(o_pready),
  .o_start_vel(o_start_vel), .o_peak_vel(o_peak_vel), .o_hold(o_hold),
  .o_stream_active(o_stream_active), .o_step_x(o_step_x), .o_step_y(o_step_y));
`default_nettype wire

// [verif/axis_motion_model.sv]
// motion stand-in that keeps axes busy for a while after a kick
`timescale 1ns/1ns
`default_nettype none
module axis_motion_model #(parameter int LEN = 40) (
  input wire logic i_sys_clk,     // clock
  input wire logic i_rst_b,       // sync reset, low active
  input wire logic [3:0] i_kick,  // start a move per axis
  output logic [3:0] o_busy       // move running
);
  int cnt [4];
  always @(posedge i_sys_clk) begin
    for (int a = 0; a < 4; a++) begin
      if (!i_rst_b) cnt[a] <= 0;
      else if (i_kick[a]) cnt[a] <= LEN;
      else if (cnt[a] > 0) cnt[a] <= cnt[a] - 1;
    end
  end
  always_comb begin
    for (int a = 0; a < 4; a++) o_busy[a] = cnt[a] != 0;
  end
endmodule
`default_nettype wire

// [verif/velocity_profile_commands_tb.sv]
// self-checking bench for the velocity profile command block
`timescale 1ns/1ns
`default_nettype none
module velocity_profile_commands_tb;
  import velocity_pkg::*;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, hold, sact, stx, dx, sty, dy, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] kick, busy;
  logic [3:0][VEL_W-1:0] start_vel, peak_vel;
  int fail_count = 0;
  int check_count = 0;
  velocity_profile_commands dut_u (.i_sys_clk(clk), .i_rst_b(rst_b), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_axis_busy(busy), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_start_vel(start_vel), .o_peak_vel(peak_vel), .o_hold(hold), .o_stream_active(sact),
    .o_step_x(stx), .o_dir_x(dx), .o_step_y(sty), .o_dir_y(dy));
  axis_motion_model mot_u (.i_sys_clk(clk), .i_rst_b(rst_b), .i_kick(kick), .o_busy(busy));
  // ====
  // helpers
  task automatic close_out();
    if (fail_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
  task automatic rdv(input logic [7:0] a); apb(1'b0, a, 32'h0); endtask
  task automatic op(input op_t o); wr(OFS_CMD, 32'(o)); endtask
  task automatic err_is(input logic [31:0] e);
    rdv(OFS_STATUS);
    chk(rd & 32'h1, e);
    wr(OFS_STATUS, 32'h1);
  endtask
  // ====
  // scenarios
  task automatic t_reset();
    op(OP_PEAK_REPORT);
    rdv(OFS_REPORT);
    chk(rd, 32'h30D40);
    op(OP_BASE_REPORT);
    rdv(OFS_REPORT);
    chk(rd, 32'h0);
    rdv(OFS_URATE);
    chk(rd, 32'h400);
    rdv(8'hFC);
    chk({31'h0, err}, 32'h1);
  endtask
  task automatic t_peak();
    logic [31:0] v [3] = '{32'h0, 32'h3D0901, 32'h3D0900};
    for (int i = 0; i < 3; i++) begin
      wr(OFS_ARG0, v[i]);
      op(OP_PEAK_SET);
      err_is(i < 2);
    end
    chk(32'(peak_vel[0]), 32'h3D0900);
    rdv(OFS_QCOST);
    chk(rd & 32'hFFFF, 32'h0101);
    wr(OFS_RAMP, 32'h1);
    op(OP_PEAK_SET);
    rdv(OFS_QCOST);
    chk(rd & 32'hFFFF, 32'h1A02);
    wr(OFS_RAMP, 32'h2);
    op(OP_PEAK_SET);
    err_is(32'h1);
    wr(OFS_RAMP, 32'h0);
  endtask
  task automatic t_base();
    wr(OFS_ARG0, 32'h12C);
    op(OP_BASE_SET);
    repeat (3) @(posedge clk);
    chk(32'(start_vel[0]), 32'h12C);
    wr(OFS_ARG0, 32'h64);
    op(OP_PEAK_SET);
    repeat (3) @(posedge clk);
    chk(32'(start_vel[0]), 32'h63);
    wr(OFS_ARG0, 32'h65);
    op(OP_BASE_SET);
    err_is(32'h1);
    // host keeps jog and separate deceleration out of these runs
    wr(OFS_RAMP, 32'h3);
    wr(OFS_ARG0, 32'h32);
    op(OP_BASE_SET);
    repeat (3) @(posedge clk);
    chk(32'(start_vel[0]), 32'h0);
    err_is(32'h0);
    wr(OFS_RAMP, 32'h0);
  endtask
  task automatic t_wait();
    wr(OFS_MODE, 32'h1);
    wr(OFS_ARG0 + 8'h4, 32'h2710);
    wr(OFS_ARG0 + 8'hC, 32'hC350);
    wr(OFS_ARG_MASK, 32'h8);
    op(OP_PEAK_SET);
    repeat (3) @(posedge clk);
    chk(32'(peak_vel[3]), 32'hC350);
    chk(32'(peak_vel[1]), 32'h30D40);
    op(OP_PEAK_REPORT);
    err_is(32'h1);
    op(OP_BASE_REPORT);
    err_is(32'h1);
    @(posedge clk);
    kick <= 4'hF;
    @(posedge clk);
    kick <= 4'h0;
    op(OP_WAIT_ALL);
    rdv(OFS_QCOST);
    chk(rd & 32'hFFFF, 32'h0002);
    chk({31'h0, hold}, 32'h1);
    wr(OFS_ARG_MASK, 32'h0);
    op(OP_PEAK_SET);
    chk({28'h0, busy}, 32'h0);
    chk({31'h0, hold}, 32'h0);
    wr(OFS_MODE, 32'h0);
  endtask
  task automatic t_rate();
    wr(OFS_ARG0, 32'hBB8);
    op(OP_RATE_SET);
    err_is(32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_ARG0, 32'h400 << i);
      op(OP_RATE_SET);
      rdv(OFS_URATE);
      chk(rd, 32'h400 << i);
    end
  endtask
  task automatic t_stream();
    int nx = 0;
    int ny = 0;
    int n = 0;
    // single-axis mode, first axis, nothing else moving
    for (int i = 0; i < 2; i++) begin
      wr(OFS_ARG0, 32'h1);
      wr(OFS_ARG0 + 8'h4, 32'hFFFF3CB0);
      wr(OFS_ARG0 + 8'h8, (i == 0) ? 32'h186A0 : 32'hFFFE7960);
      op(OP_STREAM);
    end
    err_is(32'h0);
    chk({29'h0, sact, dx, dy}, 32'h6);
    while (sact === 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
      nx += int'(stx);
      ny += int'(sty);
    end
    // two 1/8192 s ticks: about 2441 cycles, 12.2 and 24.4 steps
    chk(32'(n > 2380 && n < 2450), 32'h1);
    chk(32'(nx inside {[11:13]}), 32'h1);
    chk(32'(ny inside {[23:25]}), 32'h1);
    chk({31'h0, dy}, 32'h1);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    kick = 4'h0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_peak();
    t_base();
    t_wait();
    t_rate();
    t_stream();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out();
  end
endmodule
`default_nettype wire
